// [rtl/psfp_pkg.sv]
// Function
// (RL1) Low-side undervoltage forces all low-side drives off
// (RL2) Low-side undervoltage fault output, minimum 20us
// (RL3) After low-side recovery, phase waits input rise
// (RL4) High-side undervoltage blocks own phase, no fault
// (RL5) High-side recovery waits for input rising edge
// (RL6) Overtemp asserts fault, low-side drives forced off
// (RL7) Overtemp fault lasts 20us minimum, extended
// (RL8) Overtemp clears only at hysteresis reset level
// (RL9) After overtemp clears, phase waits input rise
// (RL10) Temperature-output variant: controller stops switching itself
// (RL11) Undervoltage ignored until 10us filter elapses
// (RL12) Inputs and flags synchronised; rising edges detected
package psfp_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int FAULT_PULSE_MIN_WIDTH_US = 20;
  localparam int UV_FILTER_US = 10;
  localparam int FAULT_PULSE_CYC = (FAULT_PULSE_MIN_WIDTH_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int UV_FILTER_CYC = (UV_FILTER_US * CLK_HZ) / 1_000_000;
  localparam int PHASES = 3;
  localparam logic [8:0] FAULT_CNT_ZERO = 9'h000;
  localparam logic [7:0] UV_CNT_ZERO = 8'h00;

  // Per-phase control inputs from the controller
  typedef struct packed {
    logic [2:0] high_in;
    logic [2:0] low_in;
  } psfp_ctrl_t;

  // Protection flags from the analog side
  typedef struct packed {
    logic low_uv;
    logic [2:0] high_uv;
    logic overtemp;
  } psfp_flags_t;

  // Switch drive outputs
  typedef struct packed {
    logic [2:0] high_drv;
    logic [2:0] low_drv;
  } psfp_drive_t;

  typedef enum logic [1:0] {
    PSFP_RUN,
    PSFP_BLOCK,
    PSFP_ARM
  } psfp_gate_t;
endpackage

// [rtl/psfp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module psfp_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_dout;

  // Two stage synchroniser, first stage read only by second
  always_comb
  begin
    next_meta = srst ? '0 : din;
    next_dout = srst ? '0 : meta;
  end

  always_ff @(posedge core_clk)
  begin
    meta <= next_meta;
    dout <= next_dout;
  end
endmodule
`default_nettype wire

// [rtl/psfp_top.sv]
`timescale 1ns/1ps
`default_nettype none
module psfp_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire psfp_pkg::psfp_ctrl_t ctrl,
  input wire psfp_pkg::psfp_flags_t flags,
  output psfp_pkg::psfp_drive_t drive,
  output logic fault_out
);
  import psfp_pkg::*;

  psfp_ctrl_t ctrl_s;
  psfp_flags_t flags_s;
  psfp_ctrl_t ctrl_d;
  psfp_ctrl_t next_ctrl_d;
  logic [7:0] low_uv_cnt;
  logic [7:0] next_low_uv_cnt;
  logic [7:0] high_uv_cnt [PHASES];
  logic [7:0] next_high_uv_cnt [PHASES];
  logic low_uv_trip;
  logic next_low_uv_trip;
  logic [2:0] high_uv_trip;
  logic [2:0] next_high_uv_trip;
  logic [8:0] fault_cnt;
  logic [8:0] next_fault_cnt;
  logic next_fault_out;
  psfp_gate_t low_gate [PHASES];
  psfp_gate_t next_low_gate [PHASES];
  psfp_gate_t high_gate [PHASES];
  psfp_gate_t next_high_gate [PHASES];
  psfp_drive_t next_drive;
  logic [2:0] low_rise;
  logic [2:0] high_rise;
  logic low_block;
  logic [2:0] prime;
  logic [2:0] next_prime;
  logic [8:0] fault_age;
  logic [8:0] next_fault_age;

  // Filter counter step: count while flag holds, hold at the filter length
  function automatic logic [7:0] filt_step(input logic flag, input logic [7:0] cnt);
    if (!flag)
      filt_step = UV_CNT_ZERO;
    else if (cnt < 8'(UV_FILTER_CYC))
      filt_step = cnt + 8'h01;
    else
      filt_step = cnt;
  endfunction

  // Gate state step: block while tripped, re-arm, run on input rise
  function automatic psfp_gate_t gate_step(input psfp_gate_t st, input logic trip,
                                           input logic rise);
    if (trip)
      gate_step = PSFP_BLOCK;
    else
    begin
      case (st)
        PSFP_BLOCK: gate_step = PSFP_ARM;
        PSFP_ARM: gate_step = rise ? PSFP_RUN : PSFP_ARM;
        default: gate_step = PSFP_RUN;
      endcase
    end
  endfunction

  // Synchronise inputs and flags
  psfp_sync #(.W(6)) u_sync_ctrl (
    .core_clk(core_clk),
    .srst(srst),
    .din(ctrl),
    .dout(ctrl_s)
  ); // RL12
  psfp_sync #(.W(5)) u_sync_flags (
    .core_clk(core_clk),
    .srst(srst),
    .din(flags),
    .dout(flags_s)
  ); // RL12

  // Rising edges of synchronised inputs; masked until the sync stages and
  // the delay flop hold real samples, so an input held high through reset
  // never counts as a fresh rise
  assign low_rise = ctrl_s.low_in & ~ctrl_d.low_in & {3{prime[2]}}; // RL12
  assign high_rise = ctrl_s.high_in & ~ctrl_d.high_in & {3{prime[2]}}; // RL12
  // Overtemp flag already carries hysteresis from the sensor comparator
  assign low_block = low_uv_trip | flags_s.overtemp; // RL8

  // Settling shift: fills with ones over the first three edges after reset
  always_comb
  begin
    next_prime = srst ? 3'h0 : {prime[1:0], 1'h1};
  end

  always_ff @(posedge core_clk)
  begin
    prime <= next_prime;
  end

  // Undervoltage filters and trip levels
  always_comb
  begin
    next_ctrl_d = srst ? '0 : ctrl_s;
    next_low_uv_cnt = srst ? UV_CNT_ZERO : filt_step(flags_s.low_uv, low_uv_cnt); // RL11
    next_low_uv_trip = !srst && flags_s.low_uv && low_uv_cnt == 8'(UV_FILTER_CYC); // RL11
    for (int i = 0; i < PHASES; i++)
    begin
      next_high_uv_cnt[i] = srst ? UV_CNT_ZERO : filt_step(flags_s.high_uv[i], high_uv_cnt[i]);
      next_high_uv_trip[i] = !srst && flags_s.high_uv[i]
                             && high_uv_cnt[i] == 8'(UV_FILTER_CYC); // RL11
    end
  end

  always_ff @(posedge core_clk)
  begin
    ctrl_d <= next_ctrl_d;
    low_uv_cnt <= next_low_uv_cnt;
    low_uv_trip <= next_low_uv_trip;
    high_uv_cnt <= next_high_uv_cnt;
    high_uv_trip <= next_high_uv_trip;
  end

  // Fault output: minimum width, extended while condition lasts
  always_comb
  begin
    next_fault_cnt = fault_cnt;
    if (srst)
      next_fault_cnt = FAULT_CNT_ZERO;
    else if (low_block)
      next_fault_cnt = 9'(FAULT_PULSE_CYC); // RL2 RL7
    else if (fault_cnt != FAULT_CNT_ZERO)
      next_fault_cnt = fault_cnt - 9'h001;
    next_fault_out = !srst && (low_block || fault_cnt > 9'h001); // RL2 RL6 RL7
  end

  always_ff @(posedge core_clk)
  begin
    fault_cnt <= next_fault_cnt;
    fault_out <= next_fault_out;
  end

  // Length of the present fault pulse, saturating at the minimum width
  always_comb
  begin
    next_fault_age = FAULT_CNT_ZERO;
    if (!srst && fault_out && fault_age < 9'(FAULT_PULSE_CYC))
      next_fault_age = fault_age + 9'h001;
    else if (!srst && fault_out)
      next_fault_age = fault_age;
  end

  always_ff @(posedge core_clk)
  begin
    fault_age <= next_fault_age;
  end

  // Gate state per phase and switch drives
  always_comb
  begin
    for (int i = 0; i < PHASES; i++)
    begin
      next_low_gate[i] = srst ? PSFP_ARM : gate_step(low_gate[i], low_block, low_rise[i]); // RL3 RL9
      next_high_gate[i] = srst ? PSFP_ARM : gate_step(high_gate[i], high_uv_trip[i],
                                                      high_rise[i]); // RL5
      next_drive.low_drv[i] = !srst && !low_block && ctrl_s.low_in[i]
                              && (low_gate[i] == PSFP_RUN || low_rise[i]
                                  && low_gate[i] == PSFP_ARM); // RL1 RL6
      next_drive.high_drv[i] = !srst && !high_uv_trip[i] && ctrl_s.high_in[i]
                               && (high_gate[i] == PSFP_RUN || high_rise[i]
                                   && high_gate[i] == PSFP_ARM); // RL4
    end
  end

  always_ff @(posedge core_clk)
  begin
    low_gate <= next_low_gate;
    high_gate <= next_high_gate;
    drive <= next_drive;
  end

  // Checks
  sequence s_low_trip;
    !srst && low_block;
  endsequence

  // Overtemp seen, then gone, with no undervoltage trip behind it
  sequence s_ot_clear;
    flags_s.overtemp ##1 (!flags_s.overtemp && !low_uv_trip);
  endsequence

  // Gate leaves the block state one cycle after the trip is gone, drive off
  sequence s_gate_release;
    low_gate[0] == PSFP_BLOCK ##1 (low_gate[0] == PSFP_ARM && !drive.low_drv[0]);
  endsequence

  AST_LOW_OFF: assert property (@(posedge core_clk) disable iff (srst) // RL1
    s_low_trip |=> drive.low_drv == 3'h0) else $error("low drive on during trip");
  AST_FAULT_ON: assert property (@(posedge core_clk) disable iff (srst) // RL2
    s_low_trip |=> fault_out) else $error("fault not raised");
  AST_FAULT_MIN: assert property (@(posedge core_clk) disable iff (srst) // RL7
    $rose(fault_out) |-> fault_out [*8]) else $error("fault pulse too short");
  AST_FAULT_CNT: assert property (@(posedge core_clk) disable iff (srst) // RL7
    $fell(fault_out) |-> $past(fault_cnt) <= 9'h002) else $error("fault ended early");
  AST_FAULT_WIDTH: assert property (@(posedge core_clk) disable iff (srst) // RL2 RL7
    $fell(fault_out) |-> fault_age == 9'(FAULT_PULSE_CYC)) else $error("fault pulse narrow");
  AST_OT_FAULT: assert property (@(posedge core_clk) disable iff (srst) // RL6
    flags_s.overtemp |=> fault_out && drive.low_drv == 3'h0) else $error("overtemp");
  AST_HIGH_KEEP: assert property (@(posedge core_clk) disable iff (srst) // RL6
    (flags_s.overtemp && !high_uv_trip[2] && high_gate[2] == PSFP_RUN && ctrl_s.high_in[2])
    |=> drive.high_drv[2]) else $error("overtemp cut high drive");
  AST_HIGH_NOFAULT: assert property (@(posedge core_clk) disable iff (srst) // RL4
    (|high_uv_trip && !low_block && fault_cnt == FAULT_CNT_ZERO) |=> !fault_out)
    else $error("high uv raised fault");
  AST_HIGH_OFF: assert property (@(posedge core_clk) disable iff (srst) // RL4
    high_uv_trip[0] |=> !drive.high_drv[0]) else $error("high drive on in uv");
  AST_REARM: assert property (@(posedge core_clk) disable iff (srst) // RL3
    (low_gate[0] == PSFP_ARM && !low_rise[0]) |=> !drive.low_drv[0])
    else $error("drive without rise");
  AST_NO_RESET_RISE: assert property (@(posedge core_clk) disable iff (srst) // RL12 RL3
    ($rose(prime[2]) && ctrl_s.low_in[0] && ctrl_d.low_in[0]) |=> !drive.low_drv[0])
    else $error("held input drove after reset");
  AST_HIGH_REARM: assert property (@(posedge core_clk) disable iff (srst) // RL5
    (high_gate[1] == PSFP_ARM && !high_rise[1]) |=> !drive.high_drv[1])
    else $error("high drive without rise");
  AST_FILTER: assert property (@(posedge core_clk) disable iff (srst) // RL11
    $rose(flags_s.low_uv) |=> !low_uv_trip) else $error("uv filter skipped");
  AST_UV_HOLD: assert property (@(posedge core_clk) disable iff (srst) // RL2
    (low_uv_trip && flags_s.low_uv) |=> low_uv_trip) else $error("uv trip dropped");
  AST_OT_PERSIST: assert property (@(posedge core_clk) disable iff (srst) // RL8 RL9
    flags_s.overtemp [*2] |-> low_gate[2] == PSFP_BLOCK) else $error("ot cleared early");
  AST_OT_RELEASE: assert property (@(posedge core_clk) disable iff (srst) // RL9
    s_ot_clear |-> s_gate_release) else $error("gate release after overtemp");
endmodule
`default_nettype wire

// [bench/psfp_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psfp_ctrl_model (
  input wire logic core_clk,
  input wire logic stop,
  input wire logic [5:0] cmd,
  output psfp_pkg::psfp_ctrl_t ctrl
);
  import psfp_pkg::*;
  // Phase commands change just after the edge, as a controller port would;
  // stop models the controller halting switching on its own reading
  initial ctrl = '0;
  always @(posedge core_clk)
  begin
    ctrl <= #2 (stop ? 6'h00 : cmd);
  end
endmodule
`default_nettype wire

// [bench/power_stage_fault_protect_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module power_stage_fault_protect_bench;
  import psfp_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] cmd = 6'h3F;
  logic ctrl_stop = 1'b0;
  psfp_ctrl_t ctrl;
  psfp_flags_t flags = '0;
  psfp_drive_t drive;
  logic fault_out;
  int n_errors = 0;
  int num_checks = 0;
  // Free-running core clock
  initial forever #50 core_clk = ~core_clk;
  psfp_ctrl_model u_ctrl (.core_clk(core_clk), .stop(ctrl_stop), .cmd(cmd), .ctrl(ctrl));
  psfp_top u_dut (.core_clk(core_clk), .srst(srst), .ctrl(ctrl), .flags(flags),
    .drive(drive), .fault_out(fault_out));
  // Ends the run with the verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Compares fault output and all six drives at once
  task automatic check(input string what, input logic [6:0] exp);
    num_checks++;
    if ({fault_out, drive} !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, {fault_out, drive});
    end
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // Fresh low-to-high on every phase input
  task automatic rearm();
    cmd = 6'h00;
    go(8);
    cmd = 6'h3F;
    go(8);
  endtask
  // Bounded wait for the fault pulse to end
  task automatic wait_fault_low(input int lim);
    int i;
    for (i = 0; i < lim && fault_out !== 1'b0; i++)
      go(1);
    if (fault_out !== 1'b0)
    begin
      n_errors++;
      $display("wrong value fault release expected 0 seen %b", fault_out);
      report_and_stop();
    end
  endtask
  task automatic t_reset();
    go(10);
    check("held input after reset", 7'h00);
    rearm();
    check("fresh rise", 7'h3F);
    $display("reset test done");
  endtask
  task automatic t_low_uv();
    flags.low_uv = 1'b1;
    go(50);
    check("inside filter", 7'h3F);
    flags.low_uv = 1'b0;
    go(10);
    check("short dip", 7'h3F);
    flags.low_uv = 1'b1;
    go(400);
    check("low uv trip", 7'h78);
    flags.low_uv = 1'b0;
    go(150);
    check("low uv fault width", 7'h78);
    wait_fault_low(100);
    check("low uv recovered", 7'h38);
    rearm();
    check("low uv rearmed", 7'h3F);
    $display("low uv test done");
  endtask
  task automatic t_high_uv();
    flags.high_uv = 3'b010;
    go(150);
    check("high uv phase 1", 7'h2F);
    flags.high_uv = 3'b000;
    go(20);
    check("high uv recovered", 7'h2F);
    rearm();
    check("high uv rearmed", 7'h3F);
    $display("high uv test done");
  endtask
  task automatic t_overtemp();
    flags.overtemp = 1'b1;
    go(3);
    flags.overtemp = 1'b0;
    go(6);
    check("short overtemp", 7'h78);
    go(150);
    check("short overtemp width", 7'h78);
    wait_fault_low(100);
    rearm();
    check("short overtemp rearmed", 7'h3F);
    flags.overtemp = 1'b1;
    go(400);
    check("long overtemp", 7'h78);
    rearm();
    check("inputs during overtemp", 7'h78);
    flags.overtemp = 1'b0;
    go(150);
    check("overtemp tail", 7'h78);
    wait_fault_low(100);
    check("overtemp cleared", 7'h38);
    rearm();
    check("overtemp rearmed", 7'h3F);
    ctrl_stop = 1'b1;
    go(6);
    check("controller stop", 7'h00);
    ctrl_stop = 1'b0;
    go(6);
    check("controller resume", 7'h3F);
    $display("overtemp test done");
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    #2;
    check("during reset", 7'h00);
    srst = 1'b0;
    t_reset();
    t_low_uv();
    t_high_uv();
    t_overtemp();
    report_and_stop();
  end
endmodule
`default_nettype wire
